// ---- design/lcc_pkg.sv ----
package lcc_pkg;
	// Clock and host wait period
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAIT_TIMEOUT_NS = 1000000;
	localparam int WAIT_TIMEOUT_CYC = WAIT_TIMEOUT_NS / CLK_PERIOD_NS;

	// Port block: four consecutive addresses from the base
	localparam logic [9:0] DEFAULT_BASE = 10'h220;
	localparam logic [9:0] BASE_LIMIT = 10'h3fc;
	localparam logic [1:0] DATA_OFS = 2'h0;
	localparam logic [1:0] CSR_OFS = 2'h3;
	localparam int CSR_OBF_BIT = 0;
	localparam int CSR_IBF_BIT = 1;

	// Channels and reply sizes
	localparam int NUM_CH = 4;
	localparam int MAX_REPLY = 6;
	localparam logic [2:0] SERIAL_REPLY_LEN = 3'd6;

	// Command codes
	localparam logic [7:0] write_comparison_enable_cmd = 8'h01;
	localparam logic [7:0] read_serial_cmd = 8'h02;
	localparam logic [7:0] relocate_base_cmd = 8'h03;
	localparam logic [7:0] read_sequence_count_cmd = 8'h04;
	localparam logic [7:0] set_outputs_cmd = 8'h05;

	// Completion and host result codes
	localparam logic [7:0] completion_success_code = 8'h00;
	localparam logic [7:0] FAIL_CODE = 8'h01;
	localparam logic [7:0] HOST_REJECT_CODE = 8'he0;
	localparam logic [7:0] input_buffer_wait_timeout = 8'hf1;
	localparam logic [7:0] output_buffer_wait_timeout = 8'hf2;

	// Argument bytes that follow each command byte
	function automatic logic [1:0] arg_count(input logic [7:0] code);
		case (code)
			write_comparison_enable_cmd: arg_count = 2'd1;
			relocate_base_cmd: arg_count = 2'd2;
			read_sequence_count_cmd: arg_count = 2'd1;
			set_outputs_cmd: arg_count = 2'd1;
			default: arg_count = 2'd0;
		endcase
	endfunction

	// Reply bytes, status byte included where one is sent
	function automatic logic [2:0] reply_count(input logic [7:0] code);
		if (code == read_serial_cmd) begin
			reply_count = SERIAL_REPLY_LEN;
		end else begin
			reply_count = 3'd1;
		end
	endfunction
endpackage

// ---- design/lcc_bus_if.sv ----
`timescale 1ns/100ps
// Byte-wide port bus between host and controller, all on one clock
interface lcc_bus_if;
	logic [9:0] io_addr;
	logic [7:0] io_wdata;
	logic io_wr;
	logic io_rd;
	logic [7:0] io_rdata;

	modport dev(input io_addr, input io_wdata, input io_wr, input io_rd, output io_rdata);
	modport host(output io_addr, output io_wdata, output io_wr, output io_rd, input io_rdata);
endinterface

// ---- design/lcc_device.sv ----
`timescale 1ns/100ps
// Function
// - Enable byte bits 0-3 gate channels 1-4
// - Upper four enable bits are ignored
// - Output on when above preset, else off
// - Enable bit clear leaves output untouched
// - Inactive channel: no measurement, output untouched
// - Newly enabled output waits for valid measurement
// - Disabled output holds last comparison state
// - Host should set outputs after enable change
// - Resume operation with newly written enables
// - Return stored serial and valid bit unchanged
// - Relocate base: store, answer only there
// - New base address accepted without checks
// - Host base keeps two low bits zero
// - Host base never above 3fc
// - Default base address is 220 hex
// - Per-channel eight-bit wrapping conversion counter
// - Counter read replies one byte, no status
// - Other commands end with status, zero success
// - Host writes only after previous byte consumed
// - Replies placed in output register for host
module lcc_device
	import lcc_pkg::*;
#(
	parameter logic [9:0] BASE_DEFAULT = DEFAULT_BASE
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	lcc_bus_if.dev bus,
	input wire logic [NUM_CH-1:0] chan_active,
	input wire logic [NUM_CH-1:0] meas_valid,
	input wire logic [NUM_CH-1:0] meas_above,
	input wire logic [NUM_CH-1:0] conv_done,
	input wire logic [31:0] serial_number,
	input wire logic serial_valid,
	output logic [NUM_CH-1:0] dout,
	output logic [NUM_CH-1:0] comp_enable,
	output logic nv_base_wr,
	output logic [9:0] nv_base_value
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARGS = 2'b01,
		ST_EXEC = 2'b10,
		ST_SEND = 2'b11
	} dev_state_e;

	dev_state_e state_reg, state_next;
	logic [9:0] base_reg;
	logic [7:0] in_reg, out_reg, rdata_reg, cmd_reg;
	logic ibf_reg, obf_reg;
	logic [7:0] arg_reg [2];
	logic [1:0] argn_reg;
	logic [8*MAX_REPLY-1:0] reply_reg, reply_fill;
	logic [2:0] rlen_reg, rlen_fill, ridx_reg;
	logic [NUM_CH-1:0] en_reg, dout_reg, dout_next;
	logic nv_wr_reg;
	logic [9:0] nv_val_reg;
	logic [7:0] seq_cnt [NUM_CH];
	logic [7:0] csr_val;

	// Address decode relative to the movable base, any base value works
	wire logic [9:0] addr_ofs = bus.io_addr - base_reg;
	wire logic addr_hit = (addr_ofs[9:2] == 8'h00);
	wire logic data_sel = addr_hit && (addr_ofs[1:0] == DATA_OFS);
	wire logic csr_sel = addr_hit && (addr_ofs[1:0] == CSR_OFS);
	wire logic host_wr = ce && bus.io_wr && data_sel;
	wire logic host_rd = ce && bus.io_rd && data_sel;
	wire logic bus_rd = ce && bus.io_rd && addr_hit;
	wire logic [7:0] rd_val = csr_sel ? csr_val : (data_sel ? out_reg : 8'h00);

	// Buffer handshake terms
	wire logic consume = ibf_reg && (state_reg == ST_IDLE || state_reg == ST_ARGS);
	wire logic send_load = (state_reg == ST_SEND) && !obf_reg;
	wire logic last_arg = consume && (state_reg == ST_ARGS) &&
		((argn_reg + 2'd1) == arg_count(cmd_reg));
	wire logic exec = (state_reg == ST_EXEC);
	wire logic exec_enable = exec && (cmd_reg == write_comparison_enable_cmd);
	wire logic exec_reloc = exec && (cmd_reg == relocate_base_cmd);
	wire logic exec_setout = exec && (cmd_reg == set_outputs_cmd);
	wire logic [9:0] new_base = {arg_reg[1][1:0], arg_reg[0]};
	wire logic [8*MAX_REPLY-1:0] serial_reply = {completion_success_code, 7'h00,
		serial_valid, serial_number};

	// Status byte seen at the control offset
	always_comb begin
		csr_val = 8'h00;
		csr_val[CSR_IBF_BIT] = ibf_reg;
		csr_val[CSR_OBF_BIT] = obf_reg;
	end

	// Command sequencer: command byte, arguments, execute, send reply
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (consume) begin
					state_next = (arg_count(in_reg) == 2'd0) ? ST_EXEC : ST_ARGS;
				end
			end
			ST_ARGS: begin
				if (last_arg) begin
					state_next = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_next = ST_SEND;
			end
			ST_SEND: begin
				if (send_load && (ridx_reg + 3'd1) == rlen_reg) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// Reply built at execute time; counter read carries no status byte
	always_comb begin
		reply_fill = '0;
		rlen_fill = reply_count(cmd_reg);
		case (cmd_reg)
			write_comparison_enable_cmd: begin
				reply_fill[7:0] = completion_success_code;
			end
			read_serial_cmd: begin
				reply_fill = serial_reply;
			end
			relocate_base_cmd: begin
				reply_fill[7:0] = completion_success_code;
			end
			read_sequence_count_cmd: begin
				reply_fill[7:0] = seq_cnt[arg_reg[0][1:0]];
			end
			set_outputs_cmd: begin
				reply_fill[7:0] = completion_success_code;
			end
			default: begin
				reply_fill[7:0] = FAIL_CODE;
			end
		endcase
	end

	// Output drive: an explicit set first, a fresh comparison overrides it
	always_comb begin
		dout_next = dout_reg;
		if (exec_setout) begin
			dout_next = arg_reg[0][NUM_CH-1:0];
		end
		for (int i = 0; i < NUM_CH; i++) begin
			// Inactive or disabled channels keep their last level
			if (chan_active[i] && en_reg[i] && meas_valid[i]) begin
				dout_next[i] = meas_above[i];
			end
		end
	end

	// Host-facing buffers; a new byte wins over a same-cycle consume
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			in_reg <= 8'h00;
			ibf_reg <= 1'b0;
			out_reg <= 8'h00;
			obf_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else if (ce) begin
			if (host_wr) begin
				in_reg <= bus.io_wdata;
			end
			ibf_reg <= host_wr | (ibf_reg & ~consume);
			if (send_load) begin
				out_reg <= reply_reg[{ridx_reg, 3'b000} +: 8];
			end
			obf_reg <= send_load | (obf_reg & ~host_rd);
			if (bus_rd) begin
				rdata_reg <= rd_val;
			end
		end
	end

	// Command capture and reply walk
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			cmd_reg <= 8'h00;
			argn_reg <= 2'd0;
			arg_reg[0] <= 8'h00;
			arg_reg[1] <= 8'h00;
			reply_reg <= '0;
			rlen_reg <= 3'd1;
			ridx_reg <= 3'd0;
		end else if (ce) begin
			state_reg <= state_next;
			if (consume && state_reg == ST_IDLE) begin
				cmd_reg <= in_reg;
				argn_reg <= 2'd0;
			end
			if (consume && state_reg == ST_ARGS) begin
				arg_reg[argn_reg[0]] <= in_reg;
				argn_reg <= argn_reg + 2'd1;
			end
			if (exec) begin
				reply_reg <= reply_fill;
				rlen_reg <= rlen_fill;
				ridx_reg <= 3'd0;
			end else if (send_load) begin
				ridx_reg <= ridx_reg + 3'd1;
			end
		end
	end

	// Operating state: enables, outputs, base latch and its store pulse
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			en_reg <= '0;
			dout_reg <= '0;
			base_reg <= BASE_DEFAULT;
			nv_wr_reg <= 1'b0;
			nv_val_reg <= BASE_DEFAULT;
		end else if (ce) begin
			if (exec_enable) begin
				en_reg <= arg_reg[0][NUM_CH-1:0];
			end
			dout_reg <= dout_next;
			if (exec_reloc) begin
				base_reg <= new_base;
				nv_val_reg <= new_base;
			end
			nv_wr_reg <= exec_reloc;
		end
	end

	// Conversion counters wrap 255 to 0 by plain overflow
	for (genvar g = 0; g < NUM_CH; g++) begin : g_seq
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				seq_cnt[g] <= 8'h00;
			end else if (ce && conv_done[g] && chan_active[g]) begin
				seq_cnt[g] <= seq_cnt[g] + 8'h01;
			end
		end
	end

	assign bus.io_rdata = rdata_reg;
	assign dout = dout_reg;
	assign comp_enable = en_reg;
	assign nv_base_wr = nv_wr_reg;
	assign nv_base_value = nv_val_reg;
endmodule

// ---- design/lcc_host.sv ----
`timescale 1ns/100ps
module lcc_host
	import lcc_pkg::*;
#(
	parameter int TIMEOUT_CYC = WAIT_TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	lcc_bus_if.host bus,
	input wire logic start,
	input wire logic [7:0] cmd,
	input wire logic [7:0] arg0,
	input wire logic [7:0] arg1,
	output logic busy,
	output logic done,
	output logic [7:0] result,
	output logic [8*MAX_REPLY-1:0] reply_data,
	output logic [9:0] cur_base
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0000,
		H_POLL = 4'b0001,
		H_WAIT = 4'b0010,
		H_CHECK = 4'b0011,
		H_WRITE = 4'b0100,
		H_WEND = 4'b0101,
		H_READ = 4'b0110,
		H_RWAIT = 4'b0111,
		H_RGET = 4'b1000
	} host_state_e;

	host_state_e state_reg;
	logic [9:0] base_reg, addr_reg;
	logic [7:0] wdata_reg, cmd_reg, a0_reg, a1_reg, result_reg;
	logic wr_reg, rd_reg, busy_reg, done_reg, tx_phase_reg;
	logic [1:0] tix_reg, ntx_reg;
	logic [2:0] rix_reg, nrx_reg;
	logic [31:0] timer_reg;
	logic [8*MAX_REPLY-1:0] reply_reg;

	// Byte selection and base checks on a relocation request
	wire logic [7:0] tx_byte = (tix_reg == 2'd0) ? cmd_reg : ((tix_reg == 2'd1) ? a0_reg : a1_reg);
	wire logic [9:0] req_base = {arg1[1:0], arg0};
	wire logic bad_base = (cmd == relocate_base_cmd) &&
		((req_base[1:0] != 2'b00) || (req_base > BASE_LIMIT));
	wire logic ibf_seen = bus.io_rdata[CSR_IBF_BIT];
	wire logic obf_seen = bus.io_rdata[CSR_OBF_BIT];
	wire logic timed_out = (timer_reg >= TIMEOUT_CYC);
	wire logic [9:0] csr_addr = base_reg + {8'h00, CSR_OFS};
	wire logic [9:0] data_addr = base_reg + {8'h00, DATA_OFS};

	// Poll status, move one byte, repeat; timer restarts per byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= H_IDLE;
			base_reg <= DEFAULT_BASE;
			addr_reg <= 10'h000;
			wdata_reg <= 8'h00;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			cmd_reg <= 8'h00;
			a0_reg <= 8'h00;
			a1_reg <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			result_reg <= 8'h00;
			tx_phase_reg <= 1'b1;
			tix_reg <= 2'd0;
			ntx_reg <= 2'd1;
			rix_reg <= 3'd0;
			nrx_reg <= 3'd1;
			timer_reg <= 32'h0000_0000;
			reply_reg <= '0;
		end else if (ce) begin
			done_reg <= 1'b0;
			if (state_reg != H_IDLE) begin
				timer_reg <= timer_reg + 32'h0000_0001;
			end
			case (state_reg)
				H_IDLE: begin
					if (start && bad_base) begin
						done_reg <= 1'b1;
						result_reg <= HOST_REJECT_CODE;
					end else if (start) begin
						cmd_reg <= cmd;
						a0_reg <= arg0;
						a1_reg <= arg1;
						ntx_reg <= arg_count(cmd) + 2'd1;
						nrx_reg <= reply_count(cmd);
						tix_reg <= 2'd0;
						rix_reg <= 3'd0;
						tx_phase_reg <= 1'b1;
						timer_reg <= 32'h0000_0000;
						busy_reg <= 1'b1;
						state_reg <= H_POLL;
					end
				end
				H_POLL: begin
					addr_reg <= csr_addr;
					rd_reg <= 1'b1;
					state_reg <= H_WAIT;
				end
				H_WAIT: begin
					rd_reg <= 1'b0;
					state_reg <= H_CHECK;
				end
				H_CHECK: begin
					if (tx_phase_reg && !ibf_seen) begin
						state_reg <= H_WRITE;
					end else if (!tx_phase_reg && obf_seen) begin
						state_reg <= H_READ;
					end else if (timed_out) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
						result_reg <= tx_phase_reg ? input_buffer_wait_timeout :
							output_buffer_wait_timeout;
						state_reg <= H_IDLE;
					end else begin
						state_reg <= H_POLL;
					end
				end
				H_WRITE: begin
					addr_reg <= data_addr;
					wdata_reg <= tx_byte;
					wr_reg <= 1'b1;
					tix_reg <= tix_reg + 2'd1;
					state_reg <= H_WEND;
				end
				H_WEND: begin
					wr_reg <= 1'b0;
					timer_reg <= 32'h0000_0000;
					if (tix_reg == ntx_reg) begin
						tx_phase_reg <= 1'b0;
						// The status of a relocation comes back at the new base
						if (cmd_reg == relocate_base_cmd) begin
							base_reg <= {a1_reg[1:0], a0_reg};
						end
					end
					state_reg <= H_POLL;
				end
				H_READ: begin
					addr_reg <= data_addr;
					rd_reg <= 1'b1;
					state_reg <= H_RWAIT;
				end
				H_RWAIT: begin
					rd_reg <= 1'b0;
					state_reg <= H_RGET;
				end
				H_RGET: begin
					reply_reg[{rix_reg, 3'b000} +: 8] <= bus.io_rdata;
					rix_reg <= rix_reg + 3'd1;
					timer_reg <= 32'h0000_0000;
					if ((rix_reg + 3'd1) == nrx_reg) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
						// Counter reads have no status byte; all 256 values are data
						result_reg <= (cmd_reg == read_sequence_count_cmd) ?
							completion_success_code : bus.io_rdata;
						state_reg <= H_IDLE;
					end else begin
						state_reg <= H_POLL;
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign bus.io_addr = addr_reg;
	assign bus.io_wdata = wdata_reg;
	assign bus.io_wr = wr_reg;
	assign bus.io_rd = rd_reg;
	assign busy = busy_reg;
	assign done = done_reg;
	assign result = result_reg;
	assign reply_data = reply_reg;
	assign cur_base = base_reg;
endmodule

// ---- tb/lcc_assertions.sv ----
`timescale 1ns/100ps
// Watches the port bus joining host and device; strobes are one-cycle host pulses
module lcc_assertions
	import lcc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [9:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_rdata
);
	// Device needs a cycle to consume, so writes never come back to back
	a_wr_spacing: assert property (@(posedge clk) disable iff (!rst_b)
		io_wr |=> !io_wr ##1 !io_wr) else $error("write strobes too close");
	a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		io_rd |=> !io_rd) else $error("read strobe longer than one cycle");
	a_no_overlap: assert property (@(posedge clk) disable iff (!rst_b)
		!(io_wr && io_rd)) else $error("read and write in one cycle");
	a_wr_data_ofs: assert property (@(posedge clk) disable iff (!rst_b)
		io_wr |-> io_addr[1:0] == DATA_OFS) else $error("write not at data offset");
	a_rd_ofs_legal: assert property (@(posedge clk) disable iff (!rst_b)
		io_rd |-> (io_addr[1:0] == DATA_OFS || io_addr[1:0] == CSR_OFS))
		else $error("read at unused offset");
	// Read data may only move on the edge after a read strobe
	a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(io_rd) |-> $stable(io_rdata)) else $error("read data moved without a read");
	a_status_upper: assert property (@(posedge clk) disable iff (!rst_b)
		io_rd && io_addr[1:0] == CSR_OFS |=> io_rdata[7:2] == 6'h00)
		else $error("status byte has upper bits set");
	a_reply_read_gap: assert property (@(posedge clk) disable iff (!rst_b)
		io_rd && io_addr[1:0] == DATA_OFS |=> !io_wr [*2])
		else $error("write right after reply read");
	// The byte must stay put once written, though the device takes it on the strobe edge
	a_wdata_hold: assert property (@(posedge clk) disable iff (!rst_b)
		io_wr |=> $stable(io_wdata)) else $error("write data moved after strobe");
endmodule

// ---- tb/load_cell_setpoint_command_logic_tb.sv ----
`timescale 1ns/100ps
module load_cell_setpoint_command_logic_tb
	import lcc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce_dev = 1'b1;
	logic start = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [7:0] arg0 = 8'h00;
	logic [7:0] arg1 = 8'h00;
	logic [3:0] chan_active = 4'h0;
	logic [3:0] meas_valid = 4'h0;
	logic [3:0] meas_above = 4'h0;
	logic [3:0] conv_done = 4'h0;
	// Arbitrary serial value for the test only
	logic [31:0] serial_number = 32'h1234abcd;
	logic serial_valid = 1'b1;
	logic busy, done, nv_base_wr;
	logic [7:0] result;
	logic [47:0] reply_data;
	logic [9:0] cur_base, nv_base_value;
	logic [3:0] dout, comp_enable;
	int n_fail = 0;
	int n_compared = 0;
	int n_nvwr = 0;

	always #5 clk = ~clk;

	lcc_bus_if bus();
	lcc_device i_lcc_device (.clk(clk), .rst_b(rst_b), .ce(ce_dev), .bus(bus),
		.chan_active(chan_active), .meas_valid(meas_valid), .meas_above(meas_above),
		.conv_done(conv_done), .serial_number(serial_number), .serial_valid(serial_valid),
		.dout(dout), .comp_enable(comp_enable), .nv_base_wr(nv_base_wr),
		.nv_base_value(nv_base_value));
	// Short host timeout keeps the stalled-device case brief
	lcc_host #(.TIMEOUT_CYC(200)) i_lcc_host (.clk(clk), .rst_b(rst_b), .ce(1'b1), .bus(bus),
		.start(start), .cmd(cmd), .arg0(arg0), .arg1(arg1), .busy(busy), .done(done),
		.result(result), .reply_data(reply_data), .cur_base(cur_base));
	lcc_assertions i_lcc_assertions (.clk(clk), .rst_b(rst_b), .io_addr(bus.io_addr),
		.io_wdata(bus.io_wdata), .io_wr(bus.io_wr), .io_rd(bus.io_rd), .io_rdata(bus.io_rdata));

	// Counts nonvolatile store pulses
	always @(posedge clk) if (nv_base_wr === 1'b1) n_nvwr <= n_nvwr + 1;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One host command; waits for done under a bound
	task automatic run_cmd(input logic [7:0] c, input logic [7:0] a0, input logic [7:0] a1);
		int i;
		@(negedge clk);
		cmd = c;
		arg0 = a0;
		arg1 = a1;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
		if (i == 3000) begin
			n_fail++;
			$display("ERROR done expected 1 seen %b", done);
			summarize();
		end
	endtask

	task automatic pulse(input logic [3:0] mv, input logic [3:0] cd);
		@(negedge clk);
		meas_valid = mv;
		conv_done = cd;
		@(negedge clk);
		meas_valid = 4'h0;
		conv_done = 4'h0;
	endtask

	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		chk("cur_base", 48'h220, cur_base);
		chk("nv_base_value", 48'h220, nv_base_value);
		chk("dout", 48'h0, dout);
		chk("busy", 48'h0, busy);
		$display("test reset done");
		// Known outputs first, then enable ch1 and ch3 with junk in the upper nibble
		run_cmd(set_outputs_cmd, 8'h02, 8'h00);
		chk("dout", 48'h2, dout);
		chan_active = 4'hf;
		meas_above = 4'hf;
		run_cmd(write_comparison_enable_cmd, 8'ha5, 8'h00);
		chk("result", 48'h0, result);
		chk("comp_enable", 48'h5, comp_enable);
		chk("dout", 48'h2, dout);
		pulse(4'hf, 4'h0);
		chk("dout", 48'h7, dout);
		// Channel 1 idle: its output must not drop
		chan_active = 4'he;
		meas_above = 4'h0;
		pulse(4'hf, 4'h0);
		chk("dout", 48'h3, dout);
		run_cmd(write_comparison_enable_cmd, 8'h00, 8'h00);
		meas_above = 4'hf;
		pulse(4'hf, 4'h0);
		chk("dout", 48'h3, dout);
		// Outputs left by the last comparison are put in a known state
		run_cmd(set_outputs_cmd, 8'h0c, 8'h00);
		chk("dout", 48'hc, dout);
		$display("test comparison done");
		run_cmd(read_serial_cmd, 8'h00, 8'h00);
		chk("reply_data", {8'h00, 8'h01, serial_number}, reply_data);
		chk("result", 48'h0, result);
		chk("comp_enable", 48'h0, comp_enable);
		chk("busy", 48'h0, busy);
		$display("test serial done");
		// Counter on ch3, then a full wrap; ch1 is idle and must not count
		repeat (3) pulse(4'h0, 4'h5);
		run_cmd(read_sequence_count_cmd, 8'h02, 8'h00);
		chk("count ch3", 48'h3, reply_data[7:0]);
		chk("result", 48'h0, result);
		run_cmd(read_sequence_count_cmd, 8'h00, 8'h00);
		chk("count ch1", 48'h0, reply_data[7:0]);
		repeat (256) pulse(4'h0, 4'h4);
		run_cmd(read_sequence_count_cmd, 8'h02, 8'h00);
		chk("count wrap", 48'h3, reply_data[7:0]);
		$display("test counter done");
		run_cmd(relocate_base_cmd, 8'h31, 8'h02);
		chk("result", {40'h0, HOST_REJECT_CODE}, result);
		run_cmd(relocate_base_cmd, 8'hfc, 8'h03);
		chk("result", 48'h0, result);
		chk("nv_base_value", 48'h3fc, nv_base_value);
		chk("nv writes", 48'h1, n_nvwr);
		chk("cur_base", 48'h3fc, cur_base);
		run_cmd(write_comparison_enable_cmd, 8'h0a, 8'h00);
		chk("comp_enable", 48'ha, comp_enable);
		$display("test relocate done");
		run_cmd(8'h07, 8'h00, 8'h00);
		chk("result", {40'h0, FAIL_CODE}, result);
		run_cmd(write_comparison_enable_cmd, 8'h00, 8'h00);
		// Frozen device never raises its output flag
		ce_dev = 1'b0;
		run_cmd(read_serial_cmd, 8'h00, 8'h00);
		chk("result", {40'h0, output_buffer_wait_timeout}, result);
		// A frozen device leaves its last byte on the bus; a count of 3 reads as input full
		ce_dev = 1'b1;
		run_cmd(read_sequence_count_cmd, 8'h02, 8'h00);
		chk("count ch3", 48'h3, reply_data[7:0]);
		ce_dev = 1'b0;
		run_cmd(read_serial_cmd, 8'h00, 8'h00);
		chk("result", {40'h0, input_buffer_wait_timeout}, result);
		$display("test timeout done");
		summarize();
	end
endmodule
